// ### link_host.sv
// serial bus master model for the register port link
`timescale 1ns/100ps
module link_host
(
    // clock
    input wire logic sys_clk,
    // link
    output logic chip_sel_n,
    output logic serial_clock_in,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic last_so = 1'b0;
    logic so_seen;

    initial
    begin
        chip_sel_n = 1'b1;
        serial_clock_in = 1'b0;
        serial_in = 1'b0;
    end

    // a released output shows the inverse of its last level
    always @(posedge sys_clk)
        if (serial_out_oe)
            last_so <= serial_out;
    assign so_seen = serial_out_oe ? serial_out : ~last_so;

    task automatic frame_start();
        @(posedge sys_clk);
        #1 chip_sel_n = 1'b0;
        #800;
    endtask : frame_start

    // the burst also ends here
    task automatic frame_end();
        chip_sel_n = 1'b1;
        serial_in = ~serial_in;
        #800;
    endtask : frame_end

    // n bits from the top of tx, clock idles low between bytes
    task automatic shift(input logic [7:0] tx, input int n,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            serial_in = tx[i];
            #400 serial_clock_in = 1'b1;
            rx[i] = so_seen;
            #400 serial_clock_in = 1'b0;
        end
        #800;
    endtask : shift
endmodule : link_host

// ### pin_sync.sv
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // pins in, settled levels out
    pin_sync_if.sync_side pins
);

    serial_port_pkg::sync_state_t st_r;
    serial_port_pkg::sync_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.stage1 = pins.raw;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '{stage1: serial_port_pkg::SYNC_RESET,
                      stage2: serial_port_pkg::SYNC_RESET};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pins.sync = st_r.stage2;

endmodule : pin_sync

// ### pin_sync_if.sv
// carries raw pin levels into the synchroniser and the settled copy back
`timescale 1ns/100ps
interface pin_sync_if;
    logic [serial_port_pkg::SYNC_W-1:0] raw;
    logic [serial_port_pkg::SYNC_W-1:0] sync;

    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface : pin_sync_if

// ### serial_port_pkg.sv
// constants, types and state layout for the serial register port
package serial_port_pkg;

    // positions of the pin inputs within the synchroniser vector
    localparam int SYNC_W = 5;
    localparam int PIN_SCK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_STRAP_HI = 3;
    localparam int PIN_STRAP_LO = 4;

    // one transfer cycle is this many serial clocks
    localparam logic [3:0] BITS_PER_CYCLE = 4'h8;

    // command byte layout
    localparam int OP_HI = 7;
    localparam int OP_LO = 6;
    localparam int ADDR_HI = 5;
    localparam int ADDR_LO = 0;

    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_NOP = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_BURST = 2'h3;

    // values after reset
    localparam logic [7:0] RDBUF_RESET = 8'h00;
    localparam logic [5:0] ADDR_RESET = 6'h00;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h02;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_WSINGLE = 2'b01,
        PH_WBURST = 2'b10
    } phase_t;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } sync_state_t;

    typedef struct packed {
        logic sck_q;
        logic cs_q;
        logic [3:0] cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic so;
        logic so_oe;
        phase_t phase;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd_buf;
        logic wr_pend;
        logic rd_pend;
        logic rd_cor;
        logic reg_wr;
        logic reg_rd;
        logic reg_cor;
    } port_state_t;

endpackage : serial_port_pkg

// ### serial_register_port.sv
// serial slave port giving an external controller access to the registers
//
// Functional notes
// - chip select fall starts a transfer; rise resets port and ends bursts.
// - serial input is sampled on each serial clock rising edge.
// - serial output changes after each serial clock falling edge.
// - a cycle is eight clocks; byte moves after the eighth falling edge.
// - every byte travels most significant bit first.
// - command byte: opcode in bits 7..6, register address in 5..0.
// - read shifts out previous data, then addressed data next cycle.
// - opcode 01 touches no register; previous data shifted out again.
// - single write takes data in cycle two, returns register readback.
// - burst write writes each following byte to same register.
// - writes read back the register next cycle, without clear-on-read.
// - readback after a transmit fifo data write may be undefined.
`timescale 1ns/100ps
module serial_register_port
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // mode straps
    input wire logic strap_hi_select,
    input wire logic strap_lo_select,
    // serial link
    input wire logic chip_sel_n,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // internal register file access
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_clear_on_read,
    input wire logic [7:0] reg_rdata
);

    pin_sync_if pins ();

    serial_port_pkg::port_state_t st_r;
    serial_port_pkg::port_state_t st_nxt;

    logic sck_s;
    logic si_s;
    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [1:0] opcode;

    assign pins.raw = {strap_lo_select, strap_hi_select, serial_in,
                       chip_sel_n, serial_clock_in};

    pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .pins(pins.sync_side)
    );

    assign sck_s = pins.sync[serial_port_pkg::PIN_SCK];
    assign si_s = pins.sync[serial_port_pkg::PIN_SI];
    // straps select this port, otherwise select is treated as idle
    assign cs_act = !pins.sync[serial_port_pkg::PIN_CS_N]
                    && pins.sync[serial_port_pkg::PIN_STRAP_HI]
                    && !pins.sync[serial_port_pkg::PIN_STRAP_LO];
    assign sck_rise = sck_s && !st_r.sck_q;
    assign sck_fall = !sck_s && st_r.sck_q;
    assign byte_done = cs_act && st_r.cs_q && sck_fall
                       && (st_r.cnt == serial_port_pkg::BITS_PER_CYCLE);
    assign opcode = st_r.shift_in[serial_port_pkg::OP_HI:
                                  serial_port_pkg::OP_LO];

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sck_q = sck_s;
        st_nxt.cs_q = cs_act;
        st_nxt.reg_wr = 1'h0;
        st_nxt.reg_rd = 1'h0;
        if (st_r.reg_rd)
        begin
            st_nxt.rd_buf = reg_rdata;
        end
        // write goes first, its readback follows one clock later
        if (st_r.wr_pend)
        begin
            st_nxt.wr_pend = 1'h0;
            st_nxt.reg_wr = 1'h1;
        end
        else if (st_r.rd_pend)
        begin
            st_nxt.rd_pend = 1'h0;
            st_nxt.reg_rd = 1'h1;
            st_nxt.reg_cor = st_r.rd_cor;
        end

        if (!cs_act)
        begin
            st_nxt.cnt = 4'h0;
            st_nxt.phase = serial_port_pkg::PH_CMD;
            st_nxt.so_oe = 1'h0;
        end
        else if (!st_r.cs_q)
        begin
            st_nxt.cnt = 4'h0;
            st_nxt.phase = serial_port_pkg::PH_CMD;
            st_nxt.shift_out = st_nxt.rd_buf;
            st_nxt.so = st_nxt.rd_buf[7];
            st_nxt.so_oe = 1'h1;
        end
        else if (sck_rise)
        begin
            st_nxt.shift_in = {st_r.shift_in[6:0], si_s};
            if (st_r.cnt != serial_port_pkg::BITS_PER_CYCLE)
            begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end
        end
        else if (byte_done)
        begin
            // byte complete: reload the output and act on the byte
            st_nxt.cnt = 4'h0;
            st_nxt.shift_out = st_nxt.rd_buf;
            st_nxt.so = st_nxt.rd_buf[7];
            unique case (st_r.phase)
                serial_port_pkg::PH_CMD:
                begin
                    st_nxt.addr = st_r.shift_in[serial_port_pkg::ADDR_HI:
                                                serial_port_pkg::ADDR_LO];
                    unique case (opcode)
                        serial_port_pkg::OP_READ:
                        begin
                            st_nxt.rd_pend = 1'h1;
                            st_nxt.rd_cor = 1'h1;
                        end
                        serial_port_pkg::OP_NOP:
                        begin
                            st_nxt.rd_pend = 1'h0;
                        end
                        serial_port_pkg::OP_WRITE:
                        begin
                            st_nxt.rd_pend = 1'h1;
                            st_nxt.rd_cor = 1'h0;
                            st_nxt.phase = serial_port_pkg::PH_WSINGLE;
                        end
                        serial_port_pkg::OP_BURST:
                        begin
                            st_nxt.rd_pend = 1'h1;
                            st_nxt.rd_cor = 1'h0;
                            st_nxt.phase = serial_port_pkg::PH_WBURST;
                        end
                    endcase
                end
                serial_port_pkg::PH_WSINGLE,
                serial_port_pkg::PH_WBURST:
                begin
                    // same readback for fifo data; host ignores it
                    st_nxt.wdata = st_r.shift_in;
                    st_nxt.wr_pend = 1'h1;
                    st_nxt.rd_pend = 1'h1;
                    st_nxt.rd_cor = 1'h0;
                    if (st_r.phase == serial_port_pkg::PH_WSINGLE)
                    begin
                        st_nxt.phase = serial_port_pkg::PH_CMD;
                    end
                end
                default:
                begin
                    st_nxt.phase = serial_port_pkg::PH_CMD;
                end
            endcase
        end
        else if (sck_fall)
        begin
            st_nxt.shift_out = {st_r.shift_out[6:0], 1'h0};
            st_nxt.so = st_r.shift_out[6];
        end

        // fresh read data replaces the stale reload before the first bit;
        // a host clocking faster than the read latency gets the old byte
        if (cs_act && st_r.cs_q && st_r.reg_rd && !sck_rise && !sck_fall
            && st_r.cnt == 4'h0)
        begin
            st_nxt.shift_out = reg_rdata;
            st_nxt.so = reg_rdata[7];
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '{sck_q: 1'h0, cs_q: 1'h0, cnt: 4'h0,
                      shift_in: 8'h00, shift_out: 8'h00, so: 1'h0,
                      so_oe: 1'h0, phase: serial_port_pkg::PH_CMD,
                      addr: serial_port_pkg::ADDR_RESET, wdata: 8'h00,
                      rd_buf: serial_port_pkg::RDBUF_RESET,
                      wr_pend: 1'h0, rd_pend: 1'h0, rd_cor: 1'h0,
                      reg_wr: 1'h0, reg_rd: 1'h0, reg_cor: 1'h0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign serial_out = st_r.so;
    assign serial_out_oe = st_r.so_oe;
    assign reg_addr = st_r.addr;
    assign reg_wdata = st_r.wdata;
    assign reg_wr = st_r.reg_wr;
    assign reg_rd = st_r.reg_rd;
    assign reg_clear_on_read = st_r.reg_cor;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_cs_rise_reset: assert property (
        st_r.cs_q && !cs_act |=> st_r.cnt == 4'h0
            && st_r.phase == serial_port_pkg::PH_CMD)
        else $error("select release did not reset the port");

    a_sample_on_rise: assert property (
        cs_act && st_r.cs_q && sck_rise |=> st_r.shift_in[0] == $past(si_s))
        else $error("input bit not sampled on rising clock");

    a_out_after_fall: assert property (
        st_r.cs_q && $past(st_r.cs_q) && $changed(st_r.so)
            |-> $past(sck_fall) || $past(st_r.reg_rd))
        else $error("output changed without a falling clock");

    a_eight_clocks: assert property (
        byte_done |-> $past(st_r.cnt) == serial_port_pkg::BITS_PER_CYCLE
            ##1 st_r.cnt == 4'h0)
        else $error("byte completed off the eighth clock");

    a_msb_first: assert property (
        cs_act && st_r.cs_q && sck_fall && !byte_done
            |=> st_r.so == $past(st_r.shift_out[6]))
        else $error("output not most significant bit first");

    a_cmd_decode: assert property (
        byte_done && st_r.phase == serial_port_pkg::PH_CMD
            |=> st_r.addr == $past(st_r.shift_in[5:0]))
        else $error("command address not captured");

    a_read_access: assert property (
        byte_done && st_r.phase == serial_port_pkg::PH_CMD
            && opcode == serial_port_pkg::OP_READ
            |=> ##1 reg_rd && reg_clear_on_read
            ##1 st_r.rd_buf == $past(reg_rdata))
        else $error("read command did not fetch the register");

    a_nop_idle: assert property (
        byte_done && st_r.phase == serial_port_pkg::PH_CMD
            && opcode == serial_port_pkg::OP_NOP
            && !st_r.rd_pend && !st_r.wr_pend |=> !reg_rd [*3])
        else $error("no-op command touched a register");

    a_write_readback: assert property (
        byte_done && st_r.phase != serial_port_pkg::PH_CMD
            |=> ##1 reg_wr && reg_wdata == $past(st_r.shift_in, 2)
            ##1 reg_rd && !reg_clear_on_read)
        else $error("write or its readback missing");

    a_burst_holds: assert property (
        byte_done && st_r.phase == serial_port_pkg::PH_WBURST
            |=> st_r.phase == serial_port_pkg::PH_WBURST)
        else $error("burst ended while select active");

    a_out_released: assert property (
        !cs_act |=> !serial_out_oe)
        else $error("output driven while deselected");

    a_fresh_load: assert property (
        cs_act && st_r.cs_q && st_r.reg_rd && !sck_rise && !sck_fall
            && st_r.cnt == 4'h0 |=> st_r.so == $past(reg_rdata[7]))
        else $error("fresh read data not put on the output");

    a_wr_pulse: assert property (
        reg_wr |=> !reg_wr && reg_rd)
        else $error("write strobe not one cycle or readback missing");

    a_select_load: assert property (
        cs_act && !st_r.cs_q && !st_r.reg_rd
            |=> serial_out_oe && st_r.so == $past(st_r.rd_buf[7]))
        else $error("select fall did not load the read buffer");

    c_read_cmd: cover property (
        byte_done && opcode == serial_port_pkg::OP_READ
            && st_r.phase == serial_port_pkg::PH_CMD);
    c_single_write: cover property (reg_wr ##1 reg_rd);
    c_burst_two: cover property (
        byte_done && st_r.phase == serial_port_pkg::PH_WBURST
            ##[1:200] byte_done && st_r.phase == serial_port_pkg::PH_WBURST);
    c_nop_cmd: cover property (
        byte_done && opcode == serial_port_pkg::OP_NOP
            && st_r.phase == serial_port_pkg::PH_CMD);
    c_abort: cover property (
        st_r.cs_q && !cs_act && st_r.cnt != 4'h0);

endmodule : serial_register_port

// ### serial_register_port_test.sv
// self-checking bench for the serial register port
`timescale 1ns/100ps
module serial_register_port_test;
    logic sys_clk;
    logic reset;
    logic strap_hi_select;
    logic strap_lo_select;
    logic chip_sel_n;
    logic serial_clock_in;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic reg_clear_on_read;
    logic [7:0] regs [64];
    logic [7:0] rx;
    int num_errors = 0;
    int compares = 0;

    // register whose value is cleared by a command read
    localparam logic [5:0] COR_ADDR = 6'h3f;

    serial_register_port i_dut
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .strap_hi_select(strap_hi_select),
        .strap_lo_select(strap_lo_select),
        .chip_sel_n(chip_sel_n),
        .serial_clock_in(serial_clock_in),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_clear_on_read(reg_clear_on_read),
        .reg_rdata(reg_rdata)
    );

    link_host i_host
    (
        .sys_clk(sys_clk),
        .chip_sel_n(chip_sel_n),
        .serial_clock_in(serial_clock_in),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );

    assign reg_rdata = regs[reg_addr];
    always @(posedge sys_clk)
    begin
        if (reg_wr)
            regs[reg_addr] <= reg_wdata;
        if (reg_rd && reg_clear_on_read && reg_addr == COR_ADDR)
            regs[reg_addr] <= 8'h00;
    end

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic [7:0] tx, input logic [7:0] exp);
        i_host.shift(tx, 8, rx);
        check("serial byte", rx, exp);
    endtask : xfer

    task automatic t_idle();
        check("oe idle", serial_out_oe, 8'h00);
        check("wr idle", reg_wr, 8'h00);
    endtask : t_idle

    task automatic t_write_read();
        i_host.frame_start();
        xfer(8'h83, 8'h00);
        xfer(8'h5a, 8'ha6);
        xfer(8'h04, 8'h5a);
        xfer(8'h40, 8'ha1);
        xfer(8'h40, 8'ha1);
        i_host.frame_end();
        check("oe released", serial_out_oe, 8'h00);
    endtask : t_write_read

    task automatic t_burst();
        i_host.frame_start();
        xfer(8'hc7, 8'ha1);
        xfer(8'h11, 8'ha2);
        xfer(8'h22, 8'h11);
        xfer(8'h33, 8'h22);
        i_host.frame_end();
        i_host.frame_start();
        xfer(8'h07, 8'h33);
        xfer(8'h40, 8'h33);
        i_host.frame_end();
    endtask : t_burst

    task automatic t_cor();
        i_host.frame_start();
        xfer(8'hbf, 8'h33);
        xfer(8'h81, 8'h9a);
        xfer(8'h7f, 8'h81);
        xfer(8'h3f, 8'h81);
        xfer(8'h3f, 8'h81);
        xfer(8'h40, 8'h00);
        i_host.frame_end();
    endtask : t_cor

    task automatic t_abort();
        i_host.frame_start();
        xfer(8'hc9, 8'h00);
        xfer(8'h11, 8'hac);
        i_host.shift(8'hff, 4, rx);
        i_host.frame_end();
        i_host.frame_start();
        xfer(8'h09, 8'h11);
        xfer(8'h40, 8'h11);
        i_host.frame_end();
    endtask : t_abort

    task automatic t_straps();
        for (int i = 0; i < 3; i++)
        begin
            {strap_hi_select, strap_lo_select} = 2'(i + (i > 1));
            i_host.frame_start();
            check("oe off", serial_out_oe, 8'h00);
            i_host.shift(8'h8a, 8, rx);
            i_host.shift(8'h55, 8, rx);
            i_host.frame_end();
        end
        strap_hi_select = 1'b1;
        strap_lo_select = 1'b0;
        i_host.frame_start();
        xfer(8'h0a, 8'h11);
        xfer(8'h40, 8'haf);
        i_host.frame_end();
    endtask : t_straps

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #3000000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        reset = 1'b1;
        strap_hi_select = 1'b1;
        strap_lo_select = 1'b0;
        for (int i = 0; i < 64; i++)
            regs[i] = 8'ha5 ^ 8'(i);
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge sys_clk);
        t_idle();
        t_write_read();
        t_burst();
        t_cor();
        t_abort();
        t_straps();
        report_and_stop();
    end
endmodule : serial_register_port_test
